// File: rtl/acs_pkg.sv
// Contract
// - Run and enable bits both set start conversion
// - Completion stores result, raises done request
// - Next conversion starts immediately while running
// - Channel write aborts and restarts conversion
// - Clearing run stops, keeps last result
// - One of eight channels converted
// - Channel change to done equals conversion time
// - Conversion time includes sampling time
// - Result has ten bit resolution
// - Approximation from bit 9 down to 0
// - Reset clears result and high byte
// - Colliding read served before update
// - Colliding control write suppresses store, irq
package acs_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [3:0] ACS_ADDR_MODE = 4'h0;
  localparam logic [3:0] ACS_ADDR_CHAN = 4'h1;
  localparam logic [3:0] ACS_ADDR_PORT = 4'h2;
  localparam logic [3:0] ACS_ADDR_RES_LO = 4'h3;
  localparam logic [3:0] ACS_ADDR_RES_HI = 4'h4;
  localparam logic [3:0] ACS_ADDR_IRQ = 4'h5;
  // ==========================================================
  // Mode register fields
  localparam int ACS_BIT_RUN = 7;
  localparam int ACS_BIT_CMP_EN = 0;
  localparam int ACS_TSEL_HI = 5;
  localparam int ACS_TSEL_LO = 3;
  localparam int ACS_OPM_HI = 2;
  localparam int ACS_OPM_LO = 1;
  // Irq register fields: flag bit 0, mask bit 1
  localparam int ACS_BIT_FLAG = 0;
  localparam int ACS_BIT_MASK = 1;
  // ==========================================================
  // Widths and reset values
  localparam int ACS_RES_W = 10;
  localparam logic [15:0] ACS_RES_RST = 16'h0000;
  localparam logic [7:0] ACS_RESH_RST = 8'h00;
  localparam logic [7:0] ACS_ZERO8 = 8'h00;
  localparam logic [7:0] ACS_IRQ_RST = 8'h02;
  // ==========================================================
  // Timing: base sample phase cycles, doubled per time-select step; base bit step cycles
  localparam int ACS_SAMPLE_BASE = 8;
  localparam int ACS_STEP_BASE = 2;
  // Wide enough for the longest sample phase, 8 shifted by 7
  localparam int ACS_CNT_W = 11;
  // Comparator synchroniser delay, added to every bit step
  localparam int ACS_SYNC_LAT = 2;
  typedef enum logic [1:0] {ACS_IDLE, ACS_SAMPLE, ACS_CONVERT, ACS_DONE} acs_state_t;
endpackage

// File: rtl/acs_sequencer.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
module acs_sequencer #(
  parameter int NUM_CH = 8,
  parameter int RES_W = acs_pkg::ACS_RES_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Comparator side
  output logic [2:0] channel_sel,
  output logic [RES_W-1:0] trial_code,
  output logic sample_en,
  input wire logic cmp_ge,
  // Interrupt request
  output logic conversion_done_irq
);
  import acs_pkg::*;

  // ==========================================================
  // State
  logic [7:0] mode_q, mode_d;
  logic [2:0] chan_q, chan_d;
  logic [7:0] port_q, port_d;
  logic [15:0] result_q, result_d;
  logic flag_q, flag_d;
  logic mask_q, mask_d;
  acs_state_t st_q, st_d;
  logic [RES_W-1:0] sar_q, sar_d;
  logic [3:0] bit_q, bit_d;
  logic [ACS_CNT_W-1:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic [RES_W-1:0] pend_val_q, pend_val_d;
  logic [7:0] rdata_q, rdata_d;
  logic cmp_s1_q, cmp_s2_q;
  logic done_pulse_q, done_pulse_d;

  logic wr_mode, wr_chan, wr_port, wr_irq, rd_res, ctl_wr, running;
  logic [ACS_CNT_W-1:0] samp_len, step_len;
  logic [RES_W-1:0] trial;

  // Comparator output comes from the analog domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_ge;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  // Address decode
  always_comb begin
    wr_mode = wr_en && (addr == ACS_ADDR_MODE);
    wr_chan = wr_en && (addr == ACS_ADDR_CHAN);
    wr_port = wr_en && (addr == ACS_ADDR_PORT);
    wr_irq = wr_en && (addr == ACS_ADDR_IRQ);
    rd_res = rd_en && ((addr == ACS_ADDR_RES_LO) || (addr == ACS_ADDR_RES_HI));
    ctl_wr = wr_mode || wr_chan || wr_port;
    running = mode_q[ACS_BIT_RUN] && mode_q[ACS_BIT_CMP_EN];
    // Conversion time covers sampling and all bit steps
    samp_len = ACS_CNT_W'(ACS_SAMPLE_BASE) << mode_q[ACS_TSEL_HI:ACS_TSEL_LO];
    // Each step outlasts the two-flop comparator delay, so the decision sees this trial
    step_len = ACS_CNT_W'(ACS_STEP_BASE) + ACS_CNT_W'(ACS_SYNC_LAT)
      + ACS_CNT_W'(mode_q[ACS_OPM_HI:ACS_OPM_LO]);
    trial = sar_q | (RES_W'(1) << bit_q);
  end

  // Register, irq and read-data next values
  always_comb begin
    mode_d = mode_q;
    chan_d = chan_q;
    port_d = port_q;
    mask_d = mask_q;
    flag_d = flag_q;
    result_d = result_q;
    pend_d = pend_q;
    pend_val_d = pend_val_q;
    rdata_d = ACS_ZERO8;
    if (wr_mode) begin
      mode_d = wdata;
    end else if (wr_chan) begin
      chan_d = wdata[2:0];
    end else if (wr_port) begin
      port_d = wdata;
    end else if (wr_irq) begin
      flag_d = wdata[ACS_BIT_FLAG];
      mask_d = wdata[ACS_BIT_MASK];
    end
    // Read mux
    if (rd_en) begin
      if (addr == ACS_ADDR_MODE) begin
        rdata_d = mode_q;
      end else if (addr == ACS_ADDR_CHAN) begin
        rdata_d = {5'h00, chan_q};
      end else if (addr == ACS_ADDR_PORT) begin
        rdata_d = port_q;
      end else if (addr == ACS_ADDR_RES_LO) begin
        rdata_d = result_q[7:0];
      end else if (addr == ACS_ADDR_RES_HI) begin
        rdata_d = result_q[15:8];
      end else if (addr == ACS_ADDR_IRQ) begin
        rdata_d = {6'h00, mask_q, flag_q};
      end
    end
    // Store a finished result, deferred past a colliding read
    if (pend_q && !rd_res) begin
      result_d = {pend_val_q, 6'h00};
      pend_d = 1'b0;
    end
    if (done_pulse_q) begin
      flag_d = 1'b1;
      if (rd_res) begin
        pend_d = 1'b1;
        pend_val_d = sar_q;
      end else begin
        result_d = {sar_q, 6'h00};
      end
    end
  end

  // Sequencer next values
  always_comb begin
    st_d = st_q;
    sar_d = sar_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    done_pulse_d = 1'b0;
    case (st_q)
      ACS_IDLE: begin
        if (running) begin
          st_d = ACS_SAMPLE;
          cnt_d = samp_len;
        end
      end
      ACS_SAMPLE: begin
        if (cnt_q <= 8'h01) begin
          st_d = ACS_CONVERT;
          bit_d = 4'(RES_W - 1);
          sar_d = '0;
          cnt_d = step_len;
        end else begin
          cnt_d = cnt_q - ACS_CNT_W'(1);
        end
      end
      ACS_CONVERT: begin
        if (cnt_q <= 8'h01) begin
          if (cmp_s2_q) begin
            sar_d = trial;
          end
          cnt_d = step_len;
          if (bit_q == 4'h0) begin
            st_d = ACS_DONE;
          end else begin
            bit_d = bit_q - 4'h1;
          end
        end else begin
          cnt_d = cnt_q - ACS_CNT_W'(1);
        end
      end
      ACS_DONE: begin
        // Control write on completion wins and drops the result
        done_pulse_d = !ctl_wr;
        st_d = ACS_SAMPLE;
        cnt_d = samp_len;
      end
      default: st_d = ACS_IDLE;
    endcase
    if (wr_chan && running) begin
      st_d = ACS_SAMPLE;
      cnt_d = samp_len;
      done_pulse_d = 1'b0;
    end
    if (!running || (wr_mode && !(wdata[ACS_BIT_RUN] && wdata[ACS_BIT_CMP_EN]))) begin
      st_d = ACS_IDLE;
      done_pulse_d = 1'b0;
    end
  end

  // Register all state except the comparator synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= ACS_ZERO8;
      chan_q <= 3'h0;
      port_q <= ACS_ZERO8;
      result_q <= ACS_RES_RST;
      flag_q <= 1'b0;
      mask_q <= 1'b1;
      st_q <= ACS_IDLE;
      sar_q <= '0;
      bit_q <= 4'h0;
      cnt_q <= '0;
      pend_q <= 1'b0;
      pend_val_q <= '0;
      rdata_q <= ACS_RESH_RST;
      done_pulse_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      chan_q <= chan_d;
      port_q <= port_d;
      result_q <= result_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
      st_q <= st_d;
      sar_q <= sar_d;
      bit_q <= bit_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      pend_val_q <= pend_val_d;
      rdata_q <= rdata_d;
      done_pulse_q <= done_pulse_d;
    end
  end

  // Outputs
  assign rdata = rdata_q;
  assign channel_sel = chan_q;
  assign trial_code = trial;
  assign sample_en = (st_q == ACS_SAMPLE);
  assign conversion_done_irq = flag_q && !mask_q;

  // ==========================================================
  // Checks
  AST_RUN_START: assert property (@(posedge clk) disable iff (rst)
    (st_q == ACS_IDLE && running && !ctl_wr) |=> st_q == ACS_SAMPLE)
    else $error("run did not start sampling");
  AST_STOP: assert property (@(posedge clk) disable iff (rst)
    (!running) |=> st_q == ACS_IDLE)
    else $error("sequencer active while stopped");
  AST_KEEP: assert property (@(posedge clk) disable iff (rst)
    (!running && !pend_q && !done_pulse_q) |=> $stable(result_q))
    else $error("result changed while stopped");
  AST_FLAG: assert property (@(posedge clk) disable iff (rst)
    (done_pulse_q) |=> flag_q)
    else $error("done flag not set");
  AST_STORE: assert property (@(posedge clk) disable iff (rst)
    (done_pulse_q && !rd_res) |=> result_q[15:6] == $past(sar_q))
    else $error("result not stored");
  AST_DEFER: assert property (@(posedge clk) disable iff (rst)
    (done_pulse_q && rd_res) |=> pend_q)
    else $error("colliding read not deferred");
  AST_RESTART: assert property (@(posedge clk) disable iff (rst)
    (wr_chan && running && !wr_mode) |=> st_q == ACS_SAMPLE && !done_pulse_q)
    else $error("channel write did not restart");
  AST_CTL_WIN: assert property (@(posedge clk) disable iff (rst)
    (st_q == ACS_DONE && ctl_wr) |=> !done_pulse_q)
    else $error("completion not suppressed");
  AST_CONT: assert property (@(posedge clk) disable iff (rst)
    (st_q == ACS_DONE && running && !wr_mode) |=> st_q == ACS_SAMPLE)
    else $error("no back to back conversion");
endmodule

// File: sim/acs_sequencer_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module acs_sequencer_test;
  import acs_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, rd;
  logic [2:0] channel_sel;
  logic [9:0] trial_code, old;
  logic sample_en, conversion_done_irq, cmp_ge;
  logic [9:0] vin [8] = '{10'h000, 10'h3ff, 10'h200, 10'h0d9, 10'h1ff, 10'h2a7, 10'h001, 10'h3fe};
  int err_total = 0, compares = 0, n, p0, p1;
  always #5 clk = ~clk;
  // Ideal comparator on the selected input
  assign cmp_ge = vin[channel_sel] >= trial_code;
  acs_sequencer u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .channel_sel(channel_sel), .trial_code(trial_code),
    .sample_en(sample_en), .cmp_ge(cmp_ge), .conversion_done_irq(conversion_done_irq));
  // ==========================================================
  // Register access: strobes driven at rising edges, results looked at mid-cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    rd = rdata;
  endtask
  // Bounded wait for the done request, cycles counted in n
  task automatic wait_irq();
    n = 0;
    while (conversion_done_irq !== 1'b1 && n < 3000) begin
      @(posedge clk); #1;
      n++;
    end
    `CHK("done request", 1'b1, conversion_done_irq)
  endtask
  // Steady period: clear flag at a completion, wait the next one
  task automatic period(output int p);
    wr(ACS_ADDR_IRQ, 8'h00);
    wait_irq();
    p = n + 2;
  endtask
  task automatic chk_res(input logic [9:0] e);
    rdr(ACS_ADDR_RES_HI);
    `CHK("result high", e[9:2], rd)
    rdr(ACS_ADDR_RES_LO);
    `CHK("result low", {e[1:0], 6'h00}, rd)
  endtask
  // ==========================================================
  // Verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    stop_test();
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdr(ACS_ADDR_RES_HI);
    `CHK("reset high byte", ACS_RESH_RST, rd)
    rdr(ACS_ADDR_RES_LO);
    `CHK("reset low byte", ACS_RES_RST[7:0], rd)
    rdr(ACS_ADDR_IRQ);
    `CHK("reset irq reg", ACS_IRQ_RST, rd)
    rdr(4'hf);
    `CHK("unmapped read", 8'h00, rd)
    `CHK("idle sampling", 1'b0, sample_en)
    $display("test reset done");
    wr(ACS_ADDR_IRQ, 8'h00);
    wr(ACS_ADDR_MODE, 8'h01);
    repeat (100) @(posedge clk);
    #1 wr(ACS_ADDR_CHAN, 8'h05);
    `CHK("channel", 3'd5, channel_sel)
    wr(ACS_ADDR_MODE, 8'h81);
    wait_irq();
    period(p0);
    chk_res(vin[5]);
    $display("test run done");
    repeat (15) @(posedge clk);
    #1 wr(ACS_ADDR_CHAN, 8'h03);
    rdr(ACS_ADDR_IRQ);
    `CHK("sticky flag", 1'b1, rd[ACS_BIT_FLAG])
    wr(ACS_ADDR_IRQ, 8'h00);
    wait_irq();
    `CHK("restart time", 1'b1, n + 4 >= p0 - 2 && n + 4 <= p0 + 2)
    chk_res(vin[3]);
    for (int c = 0; c < 8; c++) begin
      wr(ACS_ADDR_IRQ, 8'h02);
      wr(ACS_ADDR_CHAN, 8'(c));
      wr(ACS_ADDR_IRQ, 8'h00);
      wait_irq();
      chk_res(vin[c]);
    end
    $display("test channels done");
    wr(ACS_ADDR_MODE, 8'h8b);
    wr(ACS_ADDR_IRQ, 8'h00);
    wait_irq();
    period(p1);
    `CHK("time select step", 18, p1 - p0)
    wr(ACS_ADDR_IRQ, 8'h02);
    repeat (200) @(posedge clk);
    #1 `CHK("masked request", 1'b0, conversion_done_irq)
    rdr(ACS_ADDR_IRQ);
    `CHK("flag under mask", 8'h03, rd)
    $display("test timing done");
    wr(ACS_ADDR_MODE, 8'h01);
    wr(ACS_ADDR_IRQ, 8'h00);
    `CHK("stopped sampling", 1'b0, sample_en)
    old = vin[7];
    vin[7] = 10'h155;
    repeat (200) @(posedge clk);
    #1 rdr(ACS_ADDR_IRQ);
    `CHK("no completion", 8'h00, rd)
    chk_res(old);
    wr(ACS_ADDR_MODE, 8'h80);
    repeat (200) @(posedge clk);
    #1 `CHK("no enable sampling", 1'b0, sample_en)
    rdr(ACS_ADDR_IRQ);
    `CHK("no enable flag", 8'h00, rd)
    wr(ACS_ADDR_MODE, 8'h01);
    wr(ACS_ADDR_MODE, 8'h00);
    `CHK("shut down sampling", 1'b0, sample_en)
    $display("test stop done");
    stop_test();
  end
endmodule
